// ==== verilog/aux_channel_defines.vh ====
// constants for the auxiliary sensor channel block (channels 2 and 3)
// assumes a byte-wide register port on the serial interface and a shared sensor buffer
// Behaviour
// - With channel 2 enabled and length nonzero, read its slave once per sample and store from the first slot after enabled channels 0 and 1.
// - With channel 3 enabled and length nonzero, access its slave each sample; when reading, store from the first slot after enabled channels 0, 1 and 2.
// - A disabled channel makes no periodic transfers and claims no buffer slots.
// - With swap set, both bytes of a word that are read are stored in exchanged order.
// - Under swap with grouping 0, an unpaired first byte (odd start) or an unpaired last byte (address lsb zero) is stored unswapped.
// - With swap clear, bytes go to consecutive slots in the order they were read.
// - With register-phase suppression set, the transaction sends no slave register address.
// - Grouping 0 pairs addresses 0/1, 2/3 (odd closes); grouping 1 pairs 1/2, 3/4 (even closes).
// - Channel 2's four-bit length sets its bytes per transfer and its slot count.
// - Channel 3's four-bit length sets its bytes per transfer.
// - Bit 7 of channel 3's target register selects read (1) or write (0).
// - Bits 6:0 of channel 3's target register are the slave address sent in the address phase.
// - Channel 3's start register is the slave register address where the transfer begins.
// - Channel 0 takes the lowest slots and each following enabled channel starts right after the previous ones.
`ifndef AUX_CHANNEL_DEFINES_VH
`define AUX_CHANNEL_DEFINES_VH

`define OFS_CH2_CONTROL     8'h2d
`define OFS_CH3_TARGET_ADDR 8'h2e
`define OFS_CH3_START_REG   8'h2f
`define OFS_CH3_CONTROL     8'h30

`define RST_CH2_CONTROL     8'h00
`define RST_CH3_TARGET_ADDR 8'h00
`define RST_CH3_START_REG   8'h00
`define RST_CH3_CONTROL     8'h00

`define CTL_ENABLE          7
`define CTL_BYTE_SWAP       6
`define CTL_SKIP_REG_PHASE  5
`define CTL_PAIR_GROUPING   4
`define CTL_COUNT_HI        3
`define CTL_COUNT_LO        0

`define TGT_READ_NOT_WRITE  7
`define TGT_ADDR_HI         6
`define TGT_ADDR_LO         0

`endif

// ==== verilog/aux_sensor_channels.v ====
// channels 2 and 3 of the auxiliary sensor master: control registers, transfer
// sequencing per sample, buffer slot placement and byte swapping
// assumes a byte engine outside that runs the bus and reports each byte read
`include "aux_channel_defines.vh"

module aux_sensor_channels (
   input  wire       sys_clk,
   input  wire       rst_b,
   input  wire       clkEn,
   // serial interface register port
   input  wire [7:0] regAddr,
   input  wire       regWrite,
   input  wire       regRead,
   input  wire [7:0] regWrData,
   output reg  [7:0] regRdData,
   // settings of channels 0, 1 and the channel 2 target held elsewhere
   input  wire       ch0Enable,
   input  wire [3:0] ch0ByteCount,
   input  wire       ch1Enable,
   input  wire [3:0] ch1ByteCount,
   input  wire [6:0] ch2SlaveAddress,
   input  wire [7:0] ch2StartRegister,
   // sample period tick
   input  wire       samplePulse,
   // byte engine
   output wire       xferReq,
   input  wire       xferAck,
   output reg  [6:0] xferSlaveAddr,
   output reg        xferRead,
   output reg  [7:0] xferRegAddr,
   output reg        xferSkipReg,
   output reg  [3:0] xferLen,
   input  wire       rxValid,
   input  wire [7:0] rxData,
   input  wire       xferDone,
   output wire       busy,
   // shared sensor buffer write port
   output reg        bufWrite,
   output reg  [5:0] bufAddr,
   output reg  [7:0] bufData
);

   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_REQ2 = 3'd1;
   localparam [2:0] ST_RUN2 = 3'd2;
   localparam [2:0] ST_REQ3 = 3'd3;
   localparam [2:0] ST_RUN3 = 3'd4;

   reg  [7:0] ch2Control;
   reg  [7:0] ch3TargetAddr;
   reg  [7:0] ch3StartReg;
   reg  [7:0] ch3Control;

   reg  [2:0] state;
   reg        curSwap;
   reg        curGrp;
   reg        curStore;
   reg  [5:0] curBase;
   reg  [7:0] curStart;
   reg  [3:0] curLen;
   reg  [3:0] byteIdx;
   reg  [7:0] heldByte;
   reg        heldValid;
   reg        heldPend;
   reg  [5:0] heldSlot;

   // slots claimed by one channel: none while disabled
   function [5:0] slotsUsed;
      input       en;
      input [3:0] len;
      begin
         slotsUsed = en ? {2'b00, len} : 6'd0;
      end
   endfunction

   // true when the byte at this register address closes a pair
   function closesPair;
      input [7:0] a;
      input       grp;
      begin
         closesPair = grp ? ~a[0] : a[0];
      end
   endfunction

   wire       ch2En   = ch2Control[`CTL_ENABLE];
   wire [3:0] ch2Len  = ch2Control[`CTL_COUNT_HI:`CTL_COUNT_LO];
   wire       ch3En   = ch3Control[`CTL_ENABLE];
   wire [3:0] ch3Len  = ch3Control[`CTL_COUNT_HI:`CTL_COUNT_LO];
   wire       ch2Go   = ch2En && (ch2Len != 4'd0);
   wire       ch3Go   = ch3En && (ch3Len != 4'd0);

   // slot bases follow channel order
   wire [5:0] ch2Base = slotsUsed(ch0Enable, ch0ByteCount)
                      + slotsUsed(ch1Enable, ch1ByteCount);
   wire [5:0] ch3Base = ch2Base + slotsUsed(ch2En, ch2Len);

   wire [7:0] rxRegAddr = curStart + {4'h0, byteIdx};
   wire       lastByte  = (byteIdx == curLen - 4'd1);
   wire [5:0] rxSlot    = curBase + {2'b00, byteIdx};

   assign xferReq = (state == ST_REQ2) || (state == ST_REQ3);
   assign busy    = (state != ST_IDLE);

   // register port
   always @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ch2Control    <= `RST_CH2_CONTROL;
         ch3TargetAddr <= `RST_CH3_TARGET_ADDR;
         ch3StartReg   <= `RST_CH3_START_REG;
         ch3Control    <= `RST_CH3_CONTROL;
         regRdData     <= 8'h00;
      end
      else if (clkEn)
      begin
         if (regWrite)
         begin
            if (regAddr == `OFS_CH2_CONTROL)
               ch2Control <= regWrData;
            else if (regAddr == `OFS_CH3_TARGET_ADDR)
               ch3TargetAddr <= regWrData;
            else if (regAddr == `OFS_CH3_START_REG)
               ch3StartReg <= regWrData;
            else if (regAddr == `OFS_CH3_CONTROL)
               ch3Control <= regWrData;
         end
         if (regRead)
         begin
            if (regAddr == `OFS_CH2_CONTROL)
               regRdData <= ch2Control;
            else if (regAddr == `OFS_CH3_TARGET_ADDR)
               regRdData <= ch3TargetAddr;
            else if (regAddr == `OFS_CH3_START_REG)
               regRdData <= ch3StartReg;
            else if (regAddr == `OFS_CH3_CONTROL)
               regRdData <= ch3Control;
            else
               regRdData <= 8'h00;
         end
      end
   end

   // sequencing and byte placement
   always @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state         <= ST_IDLE;
         curSwap       <= 1'b0;
         curGrp        <= 1'b0;
         curStore      <= 1'b0;
         curBase       <= 6'd0;
         curStart      <= 8'h00;
         curLen        <= 4'd0;
         byteIdx       <= 4'd0;
         heldByte      <= 8'h00;
         heldValid     <= 1'b0;
         heldPend      <= 1'b0;
         heldSlot      <= 6'd0;
         xferSlaveAddr <= 7'd0;
         xferRead      <= 1'b0;
         xferRegAddr   <= 8'h00;
         xferSkipReg   <= 1'b0;
         xferLen       <= 4'd0;
         bufWrite      <= 1'b0;
         bufAddr       <= 6'd0;
         bufData       <= 8'h00;
      end
      else if (clkEn)
      begin
         bufWrite <= 1'b0;
         if (heldPend)
         begin
            // second half of a swapped pair goes to the later slot
            bufWrite <= 1'b1;
            bufAddr  <= heldSlot;
            bufData  <= heldByte;
            heldPend <= 1'b0;
         end
         case (state)
            ST_IDLE:
            begin
               byteIdx   <= 4'd0;
               heldValid <= 1'b0;
               if (samplePulse && ch2Go)
               begin
                  state         <= ST_REQ2;
                  curSwap       <= ch2Control[`CTL_BYTE_SWAP];
                  curGrp        <= ch2Control[`CTL_PAIR_GROUPING];
                  curStore      <= 1'b1;
                  curBase       <= ch2Base;
                  curStart      <= ch2StartRegister;
                  curLen        <= ch2Len;
                  xferSlaveAddr <= ch2SlaveAddress;
                  xferRead      <= 1'b1;
                  xferRegAddr   <= ch2StartRegister;
                  xferSkipReg   <= ch2Control[`CTL_SKIP_REG_PHASE];
                  xferLen       <= ch2Len;
               end
               else if (samplePulse && ch3Go)
                  state <= ST_REQ3;
            end
            ST_REQ2, ST_REQ3:
            begin
               if (state == ST_REQ3)
               begin
                  curSwap       <= ch3Control[`CTL_BYTE_SWAP];
                  curGrp        <= ch3Control[`CTL_PAIR_GROUPING];
                  curStore      <= ch3TargetAddr[`TGT_READ_NOT_WRITE];
                  curBase       <= ch3Base;
                  curStart      <= ch3StartReg;
                  curLen        <= ch3Len;
                  xferSlaveAddr <= ch3TargetAddr[`TGT_ADDR_HI:`TGT_ADDR_LO];
                  xferRead      <= ch3TargetAddr[`TGT_READ_NOT_WRITE];
                  xferRegAddr   <= ch3StartReg;
                  xferSkipReg   <= ch3Control[`CTL_SKIP_REG_PHASE];
                  xferLen       <= ch3Len;
               end
               if (xferAck)
                  state <= (state == ST_REQ2) ? ST_RUN2 : ST_RUN3;
            end
            ST_RUN2, ST_RUN3:
            begin
               if (rxValid && curStore)
               begin
                  byteIdx <= byteIdx + 4'd1;
                  if (curSwap && !closesPair(rxRegAddr, curGrp) && !lastByte)
                  begin
                     // pair opener waits for its partner
                     heldByte  <= rxData;
                     heldSlot  <= rxSlot + 6'd1;
                     heldValid <= 1'b1;
                  end
                  else if (curSwap && heldValid)
                  begin
                     bufWrite  <= 1'b1;
                     bufAddr   <= rxSlot - 6'd1;
                     bufData   <= rxData;
                     heldPend  <= 1'b1;
                     heldValid <= 1'b0;
                  end
                  else
                  begin
                     // unpaired or unswapped byte keeps its own slot
                     bufWrite <= 1'b1;
                     bufAddr  <= rxSlot;
                     bufData  <= rxData;
                  end
               end
               if (xferDone)
               begin
                  byteIdx   <= 4'd0;
                  heldValid <= 1'b0;
                  if (state == ST_RUN2 && ch3Go)
                     state <= ST_REQ3;
                  else
                     state <= ST_IDLE;
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

endmodule // aux_sensor_channels

// ==== testbench/aux_sensor_channels_chk.sv ====
// port checks for the channel block
// assumes clkEn is taken low only while the block is idle
module aux_sensor_channels_chk (
   input wire logic       sys_clk,
   input wire logic       rst_b,
   input wire logic       regRead,
   input wire logic       samplePulse,
   input wire logic       xferReq,
   input wire logic       xferAck,
   input wire logic       rxValid,
   input wire logic       xferDone,
   input wire logic       busy,
   input wire logic       bufWrite,
   input wire logic [7:0] regRdData,
   input wire logic [6:0] xferSlaveAddr,
   input wire logic [3:0] xferLen,
   input wire logic [5:0] bufAddr
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   AST_REQ_STANDS: assert property (xferReq && !xferAck |=> xferReq)
      else $error("request dropped before ack");
   AST_ACK_RUNS: assert property (xferReq && xferAck |=> !xferReq && busy)
      else $error("no transfer after ack");
   AST_REQ_CAUSE: assert property ($rose(xferReq) |-> $past(samplePulse) || $past(xferDone))
      else $error("request without sample or previous done");
   AST_DONE_NEXT: assert property (xferDone |=> xferReq || !busy)
      else $error("no next request or idle after done");
   AST_LEN_NONZERO: assert property (xferReq && xferAck |-> xferLen != 4'h0)
      else $error("zero length transfer requested");
   AST_BUF_CAUSE: assert property (bufWrite |-> $past(rxValid) || $past(rxValid, 2))
      else $error("buffer write without received byte");
   AST_PAIR_ORDER: assert property (bufWrite && $past(bufWrite) |-> bufAddr == $past(bufAddr) + 6'h01)
      else $error("swapped pair not in adjacent slots");
   AST_FIELDS_STAND: assert property (busy && !xferReq && $past(busy && !xferReq)
      |-> $stable(xferSlaveAddr) && $stable(xferLen))
      else $error("transfer fields changed mid transfer");
   AST_RD_HOLDS: assert property (!$past(regRead) |-> $stable(regRdData))
      else $error("read data changed without read");
endmodule // aux_sensor_channels_chk

bind aux_sensor_channels aux_sensor_channels_chk aux_sensor_channels_chk_i (.*);

// ==== testbench/aux_byte_engine_model.sv ====
// behavioural byte engine facing the channel block
// each byte read carries its own register address as data
module aux_byte_engine_model (
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   input  wire logic       xferReq,
   input  wire logic       xferRead,
   input  wire logic [7:0] xferRegAddr,
   input  wire logic [3:0] xferLen,
   input  wire logic [3:0] gap,
   output logic            xferAck,
   output logic            rxValid,
   output logic            xferDone,
   output logic      [7:0] rxData
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] a;
   logic [3:0] n;
   logic       rd;
   initial
   begin
      {xferAck, rxValid, xferDone, rxData} = 11'h000;
      forever
      begin
         @(posedge sys_clk);
         if (rst_b && xferReq)
         begin
            repeat (gap + 1) @(posedge sys_clk);
            #1 xferAck = 1'b1;
            @(posedge sys_clk);
            #1 xferAck = 1'b0;
            {a, n, rd} = {xferRegAddr, xferLen, xferRead};
            repeat (rd ? n : 0)
            begin
               repeat (gap + 1) @(posedge sys_clk);
               #1 {rxValid, rxData} = {1'b1, a};
               @(posedge sys_clk);
               // released data line shows the inverse
               #1 {rxValid, rxData, a} = {1'b0, ~a, a + 8'h01};
            end
            @(posedge sys_clk);
            #1 xferDone = 1'b1;
            @(posedge sys_clk);
            #1 xferDone = 1'b0;
         end
      end
   end
endmodule // aux_byte_engine_model

// ==== testbench/aux_sensor_channels_tb_top.sv ====
// bench for the channel block: table of sample cases, then edge cases
// assumes the byte engine model returns register addresses as data
`include "aux_channel_defines.vh"
module aux_sensor_channels_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic e0, e1; logic [3:0] l0, l1, g; logic [7:0] c2, s2, t3, s3, c3;} row_t;
   logic sys_clk = 0, rst_b = 0, clkEn = 1, regWrite = 0, regRead = 0, samplePulse = 0;
   logic ch0Enable = 0, ch1Enable = 0;
   logic [7:0] regAddr = 0, regWrData = 0, ch2StartRegister = 0, rdv;
   logic [3:0] ch0ByteCount = 0, ch1ByteCount = 0, gap = 1;
   logic [6:0] ch2SlaveAddress = 7'h2a;
   wire        xferReq, xferAck, xferRead, xferSkipReg, rxValid, xferDone, busy, bufWrite;
   wire [6:0]  xferSlaveAddr;
   wire [7:0]  regRdData, xferRegAddr, rxData, bufData;
   wire [3:0]  xferLen;
   wire [5:0]  bufAddr;
   logic [7:0] mem [64], ex [64];
   logic [20:0] got [$], want [$];
   row_t rows [4];
   int n_errors = 0, num_checks = 0, r, k;
   aux_sensor_channels aux_sensor_channels_i (.*);
   aux_byte_engine_model aux_byte_engine_model_i (.*);
   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (bufWrite === 1'b1) mem[bufAddr] <= bufData;
   always @(posedge sys_clk)
      if (xferReq && xferAck)
         got.push_back({xferSlaveAddr, xferRead, xferRegAddr, xferSkipReg, xferLen});
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] gv, ev, input string m);
      num_checks++;
      if (gv !== ev)
      begin
         n_errors++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task automatic chkX(input logic [20:0] gv, ev);
      chk8({3'h0, gv[20:16]} ^ 8'h00, {3'h0, ev[20:16]}, "transfer target");
      chk8(gv[15:8], ev[15:8], "transfer register");
      chk8(gv[7:0], ev[7:0], "transfer mode and length");
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge sys_clk);
      #1 {regAddr, regWrData, regWrite} = {a, d, 1'b1};
      @(posedge sys_clk);
      #1 regWrite = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      #1 {regAddr, regRead} = {a, 1'b1};
      @(posedge sys_clk);
      #1 regRead = 1'b0;
      rdv = regRdData;
   endtask
   task automatic pulse();
      @(posedge sys_clk);
      #1 samplePulse = 1'b1;
      @(posedge sys_clk);
      #1 samplePulse = 1'b0;
   endtask
   task automatic sample();
      pulse();
      for (k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge sys_clk);
      if (k == 3000)
      begin
         chk8(8'h00, 8'h01, "timeout");
         conclude();
      end
      repeat (3) @(posedge sys_clk);
      #1;
   endtask
   // expected slots: byte value equals its register address, pairs exchanged under swap
   task automatic place(input int b, input logic [7:0] s, c);
      int i;
      logic [7:0] a;
      i = 0;
      while (i < c[3:0])
      begin
         a = s + 8'(i);
         if (c[6] && a[0] == c[4] && i + 1 < c[3:0])
         begin
            {ex[b + i], ex[b + i + 1]} = {a + 8'h01, a};
            i += 2;
         end
         else
         begin
            ex[b + i] = a;
            i++;
         end
      end
   endtask
   task automatic runRow(input row_t w);
      int b2, b3;
      {ch0Enable, ch1Enable, ch0ByteCount, ch1ByteCount, gap} = {w.e0, w.e1, w.l0, w.l1, w.g};
      ch2StartRegister = w.s2;
      wr(`OFS_CH2_CONTROL, w.c2);
      wr(`OFS_CH3_TARGET_ADDR, w.t3);
      wr(`OFS_CH3_START_REG, w.s3);
      wr(`OFS_CH3_CONTROL, w.c3);
      rd(`OFS_CH3_TARGET_ADDR);
      chk8(rdv, w.t3, "target readback");
      rd(`OFS_CH3_CONTROL);
      chk8(rdv, w.c3, "control readback");
      foreach (mem[i]) {mem[i], ex[i]} = 16'heeee;
      got.delete();
      want.delete();
      b2 = (w.e0 ? int'(w.l0) : 0) + (w.e1 ? int'(w.l1) : 0);
      b3 = b2 + (w.c2[7] ? int'(w.c2[3:0]) : 0);
      if (w.c2[7] && w.c2[3:0] != 0) place(b2, w.s2, w.c2);
      if (w.c2[7] && w.c2[3:0] != 0) want.push_back({7'h2a, 1'b1, w.s2, w.c2[5], w.c2[3:0]});
      if (w.c3[7] && w.c3[3:0] != 0 && w.t3[7]) place(b3, w.s3, w.c3);
      if (w.c3[7] && w.c3[3:0] != 0)
         want.push_back({w.t3[6:0], w.t3[7], w.s3, w.c3[5], w.c3[3:0]});
      sample();
      chk8(8'(got.size()), 8'(want.size()), "transfer count");
      foreach (want[i]) chkX(got[i], want[i]);
      foreach (mem[i]) chk8(mem[i], ex[i], "buffer slot");
   endtask
   initial
   begin
      rows[0] = '{1, 0, 3, 5, 1, 8'hc4, 8'h01, 8'h95, 8'h02, 8'h83};
      rows[1] = '{1, 1, 2, 3, 4, 8'hf5, 8'h01, 8'hc0, 8'h03, 8'he4};
      rows[2] = '{0, 1, 0, 15, 0, 8'h05, 8'h10, 8'h81, 8'hfe, 8'h8f};
      rows[3] = '{1, 1, 4, 4, 2, 8'h00, 8'h00, 8'h12, 8'h20, 8'h82};
      repeat (20) @(posedge sys_clk);
      #1 rst_b = 1'b1;
      for (r = 0; r < 4; r++)
      begin
         runRow(rows[r]);
         $display("row %0d done", r);
      end
      wr(8'h31, 8'h5a);
      rd(8'h31);
      chk8(rdv, 8'h00, "unmapped read");
      $display("unmapped access done");
      wr(`OFS_CH2_CONTROL, 8'h82);
      wr(`OFS_CH3_CONTROL, 8'h00);
      got.delete();
      pulse();
      sample();
      chk8(8'(got.size()), 8'h01, "pulse while busy");
      $display("busy pulse done");
      pulse();
      repeat (4) @(posedge sys_clk);
      #1 rst_b = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 rst_b = 1'b1;
      chk8({7'h00, busy}, 8'h00, "busy after reset");
      for (r = 8'h2d; r < 8'h31; r++)
      begin
         rd(8'(r));
         chk8(rdv, 8'h00, "reset value");
      end
      $display("reset test done");
      repeat (100) @(posedge sys_clk);
      // frozen block must ignore both a write and a sample tick
      wr(`OFS_CH2_CONTROL, 8'h82);
      clkEn = 1'b0;
      wr(`OFS_CH3_START_REG, 8'h77);
      pulse();
      clkEn = 1'b1;
      chk8({7'h00, busy}, 8'h00, "busy while frozen");
      rd(`OFS_CH3_START_REG);
      chk8(rdv, 8'h00, "write while frozen");
      $display("clock enable test done");
      conclude();
   end
endmodule // aux_sensor_channels_tb_top
